// ### design/sub_exec_defines.svh
`ifndef SUB_EXEC_DEFINES_SVH
`define SUB_EXEC_DEFINES_SVH
`define OP_SUB_W_FROM_LITERAL 8'h08
`define OP_SUB_W_FROM_FILE 6'h17
`define OP_MOVE_OFFSET 8'hEB
`define OP_MOVE_SECOND 4'hF
`define OP_PUSH_LITERAL 8'hEA
`define OP_SUB_FROM_POINTER 8'hE9
`define PTR_FIELD_RETURN 2'h3
`define INDEXED_LIMIT 8'h5F
`define ACCESS_HI_BASE 12'hF00
`define STATUS_RESET 5'h00
`define FLAG_N 4
`define FLAG_OV 3
`define FLAG_Z 2
`define FLAG_DC 1
`define FLAG_C 0
`define INDIRECT_LO 12'hFE1
`endif

// ### design/sub_exec_pkg.sv
package sub_exec_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] data;
    logic we;
    logic re;
  } mem_req_s;
  typedef enum logic [1:0] {ST_IDLE, ST_MOVE_DEST, ST_RET_NOP} exec_state_e;
endpackage

// ### design/sub_indexed_exec.sv
// Operation
// - literal equal to w gives zero, carry and zero set, negative clear.
// - literal below w gives wrapped difference, carry clear, negative from result bit 7.
// - file minus w; destination bit picks w or file register.
// - access bit 0 selects access bank, 1 uses bank select register.
// - access 0 with extended set and address up to 5Fh is frame-indexed.
// - move offset to offset is two words, two cycles, EB then F opcodes.
// - move addresses are frame pointer plus 7-bit offsets; indirect source reads zero, indirect dest is not written.
// - pointer minus unsigned 6-bit literal in one cycle, no flags.
// - pointer field selects pointer 0 to 2, literal ranges 0 to 63.
// - field 11 subtracts from frame pointer and loads pc from stack.
`include "sub_exec_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sub_indexed_exec
  import sub_exec_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic extended_en_i,
  input wire logic [3:0] bank_select_register_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic [20:0] return_stack_top_i,
  output logic [7:0] w_o,
  output logic [4:0] status_o,
  output logic [11:0] fsr0_o,
  output logic [11:0] fsr1_o,
  output logic [11:0] frame_pointer_o,
  output mem_req_s mem_req_o,
  output logic pc_load_o,
  output logic [20:0] pc_target_o,
  output logic busy_o
);
  logic [7:0] w_ff;
  logic [4:0] status_ff;
  logic [11:0] fsr_ff [3];
  exec_state_e state_ff;
  logic [11:0] src_addr_ff;
  logic pc_load_ff;
  logic [20:0] pc_target_ff;
  mem_req_s req_ff;
  logic [7:0] byte_ff;

  // combinational decode; file operand arrives on mem_rdata_i same cycle
  logic is_sub_w_from_literal, is_sub_w_from_file, is_move, is_push, is_subptr;
  logic [1:0] ptr_sel;
  logic [7:0] opa, diff;
  logic [8:0] wide;
  logic [4:0] nxt_status;
  logic [11:0] file_addr;
  assign is_sub_w_from_literal = instr_i[15:8] == `OP_SUB_W_FROM_LITERAL;
  assign is_sub_w_from_file = instr_i[15:10] == `OP_SUB_W_FROM_FILE;
  assign is_move = instr_i[15:8] == `OP_MOVE_OFFSET;
  assign is_push = instr_i[15:8] == `OP_PUSH_LITERAL;
  assign is_subptr = instr_i[15:8] == `OP_SUB_FROM_POINTER;
  assign ptr_sel = instr_i[7:6];

  always_comb
  begin
    if (!instr_i[8] && extended_en_i && instr_i[7:0] <= `INDEXED_LIMIT)
      file_addr = fsr_ff[2] + {4'h0, instr_i[7:0]};
    else if (!instr_i[8])
      file_addr = (instr_i[7] ? `ACCESS_HI_BASE : 12'h000)
        | {4'h0, instr_i[7:0]};
    else
      file_addr = {bank_select_register_i, instr_i[7:0]};
  end

  // borrow form: carry high means no borrow
  assign opa = is_sub_w_from_literal ? instr_i[7:0] : mem_rdata_i;
  assign wide = {1'b0, opa} + {1'b0, ~w_ff} + 9'h001;
  assign diff = wide[7:0];
  always_comb
  begin
    nxt_status = status_ff;
    nxt_status[`FLAG_C] = wide[8];
    nxt_status[`FLAG_DC] = ({1'b0, opa[3:0]} + {1'b0, ~w_ff[3:0]}
      + 5'h01) > 5'h0F;
    nxt_status[`FLAG_Z] = diff == 8'h00;
    nxt_status[`FLAG_N] = diff[7];
    nxt_status[`FLAG_OV] = (opa[7] != w_ff[7]) && (diff[7] != opa[7]);
  end

  function automatic logic is_indirect(input logic [11:0] a);
    // indirect ports sit at offsets 3 to 7 of every 8-byte group from FE0h upward
    is_indirect = a >= `INDIRECT_LO && a[2:0] >= 3'h3 && a[2:0] <= 3'h7
      && a[7:4] >= 4'hE;
  endfunction

  logic go;
  assign go = instr_valid_i && state_ff == ST_IDLE;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      w_ff <= 8'h00;
    else if (go && (is_sub_w_from_literal || (is_sub_w_from_file && !instr_i[9])))
      w_ff <= diff;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      status_ff <= `STATUS_RESET;
    else if (go && (is_sub_w_from_literal || is_sub_w_from_file))
      status_ff <= nxt_status;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      fsr_ff[0] <= 12'h000;
      fsr_ff[1] <= 12'h000;
      fsr_ff[2] <= 12'h000;
    end
    else if (go && is_push)
      fsr_ff[2] <= fsr_ff[2] - 12'h001;
    else if (go && is_subptr)
    begin
      if (ptr_sel == `PTR_FIELD_RETURN)
        fsr_ff[2] <= fsr_ff[2] - {6'h00, instr_i[5:0]};
      else
        fsr_ff[ptr_sel] <= fsr_ff[ptr_sel]
          - {6'h00, instr_i[5:0]};
    end
  end

  // move: cycle 1 reads source, cycle 2 takes word 2 and holds the byte; dest write follows a cycle later
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= ST_IDLE;
      src_addr_ff <= 12'h000;
      byte_ff <= 8'h00;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          if (go && is_move)
          begin
            state_ff <= ST_MOVE_DEST;
            src_addr_ff <= fsr_ff[2] + {5'h00, instr_i[6:0]};
          end
          else if (go && is_subptr && ptr_sel == `PTR_FIELD_RETURN)
            state_ff <= ST_RET_NOP;
        end
        ST_MOVE_DEST:
        begin
          if (instr_valid_i && instr_i[15:12] == `OP_MOVE_SECOND)
            state_ff <= ST_IDLE;
          // source read lands here; indirect source reads as zero
          byte_ff <= is_indirect(src_addr_ff) ? 8'h00
            : mem_rdata_i;
        end
        ST_RET_NOP:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // memory request registered; move dest write issued one cycle after word 2
  logic move_wr_ff;
  logic [11:0] dst_addr_ff;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      req_ff <= '0;
      move_wr_ff <= 1'b0;
      dst_addr_ff <= 12'h000;
    end
    else
    begin
      req_ff <= '0;
      move_wr_ff <= 1'b0;
      if (go && is_move)
      begin
        req_ff.addr <= fsr_ff[2] + {5'h00, instr_i[6:0]};
        req_ff.re <= 1'b1;
      end
      else if (state_ff == ST_MOVE_DEST && instr_valid_i
        && instr_i[15:12] == `OP_MOVE_SECOND)
      begin
        move_wr_ff <= 1'b1;
        dst_addr_ff <= fsr_ff[2] + {5'h00, instr_i[6:0]};
      end
      else if (go && is_push)
      begin
        req_ff.addr <= fsr_ff[2];
        req_ff.data <= instr_i[7:0];
        req_ff.we <= 1'b1;
      end
      else if (go && is_sub_w_from_file && instr_i[9])
      begin
        req_ff.addr <= file_addr;
        req_ff.data <= diff;
        req_ff.we <= 1'b1;
      end
      if (move_wr_ff)
      begin
        req_ff.addr <= dst_addr_ff;
        req_ff.data <= byte_ff;
        // program counter and stack bytes are assumed never named
        req_ff.we <= !is_indirect(dst_addr_ff);
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      pc_load_ff <= 1'b0;
      pc_target_ff <= 21'h0_0000;
    end
    else
    begin
      pc_load_ff <= go && is_subptr && ptr_sel == `PTR_FIELD_RETURN;
      pc_target_ff <= return_stack_top_i;
    end
  end

  assign w_o = w_ff;
  assign status_o = status_ff;
  assign fsr0_o = fsr_ff[0];
  assign fsr1_o = fsr_ff[1];
  assign frame_pointer_o = fsr_ff[2];
  assign mem_req_o = req_ff;
  assign pc_load_o = pc_load_ff;
  assign pc_target_o = pc_target_ff;
  assign busy_o = state_ff != ST_IDLE || move_wr_ff;
endmodule
`default_nettype wire

// ### dv/sub_exec_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module sub_exec_mem_model
  import sub_exec_pkg::*;
(
  input wire logic ref_clk_i,
  input wire mem_req_s mem_req_i,
  input wire logic [7:0] operand_i,
  output logic [7:0] mem_rdata_o
);
  logic [7:0] mem [4096];
  // file operand from bench unless a read is pending
  assign mem_rdata_o = mem_req_i.re ? mem[mem_req_i.addr] : operand_i;
  always @(posedge ref_clk_i)
    if (mem_req_i.we) mem[mem_req_i.addr] <= mem_req_i.data;
endmodule
`default_nettype wire

// ### dv/sub_indexed_exec_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sub_indexed_exec_chk
  import sub_exec_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [7:0] w_o,
  input wire logic [4:0] status_o,
  input wire logic [11:0] frame_pointer_o,
  input wire mem_req_s mem_req_o,
  input wire logic pc_load_o,
  input wire logic busy_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  wire lw = instr_valid_i && instr_i[15:8] == 8'h08;
  wire lit = lw && !busy_o;
  wire tk = instr_valid_i && !busy_o;
  wire psh = tk && instr_i[15:8] == 8'hEA;
  wire ptr = tk && instr_i[15:8] == 8'hE9;
  wire mv = tk && instr_i[15:8] == 8'hEB;
  wire ret = ptr && instr_i[7:6] == 2'h3;
  sequence pc_pulse;
    pc_load_o ##1 !pc_load_o;
  endsequence
  lit_zero_a: assert property (lit && instr_i[7:0] == w_o |=>
    w_o == 8'h00 && status_o[4:2] == 3'h1 && status_o[0])
    else $error("equal literal result wrong");
  lit_neg_a: assert property (lit && instr_i[7:0] < w_o |=>
    w_o == $past(instr_i[7:0]) - $past(w_o) && status_o[4] == w_o[7] &&
    !status_o[2] && !status_o[0]) else $error("borrow result wrong");
  push_dec_a: assert property (psh |=>
    frame_pointer_o == $past(frame_pointer_o) - 12'h001 && $stable(status_o))
    else $error("push pointer wrong");
  push_wr_a: assert property (psh |=> mem_req_o.we &&
    mem_req_o.addr == $past(frame_pointer_o) &&
    mem_req_o.data == $past(instr_i[7:0])) else $error("push write wrong");
  move_rd_a: assert property (mv |=> busy_o &&
    mem_req_o.re &&
    mem_req_o.addr == frame_pointer_o + {5'h00, $past(instr_i[6:0])})
    else $error("move source read wrong");
  ptr_sub_a: assert property (ptr |=> $stable(status_o) &&
    (!$past(instr_i[7]) || frame_pointer_o ==
    $past(frame_pointer_o) - {6'h00, $past(instr_i[5:0])}))
    else $error("pointer subtract wrong");
  ret_pc_a: assert property (ret |=>
    busy_o ##[0:1] pc_pulse) else $error("return sequence wrong");
  busy_ign_a: assert property (busy_o && lw |=>
    $stable(w_o) && $stable(status_o)) else $error("ignored word acted");
endmodule
`default_nettype wire

// ### dv/tb_sub_indexed_exec.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sub_indexed_exec import sub_exec_pkg::*;
;
  logic ref_clk_i = 0, rst_n_i = 0, vld = 0, ext = 0, program_counter_low, busy;
  logic [15:0] ins = 16'h0000;
  logic [3:0] bank_select_register = 4'h0;
  logic [7:0] opnd = 8'h00, rd, w;
  logic [20:0] return_stack_top = 21'h1_2345, pct;
  logic [4:0] st;
  logic [11:0] f0, f1, fp;
  mem_req_s mq;
  int failures = 0, checks_done = 0;
  logic [7:0] lk [3] = '{8'h02, 8'h01, 8'hFF};
  logic [7:0] ew [3] = '{8'h02, 8'hFF, 8'h00};
  logic [4:0] es [3] = '{5'h03, 5'h10, 5'h07};
  logic [15:0] xi [3] = '{16'h5F22, 16'h5E90, 16'h5E10};
  logic [11:0] xa [3] = '{12'h322, 12'hF90, 12'h010};
  always #25 ref_clk_i = ~ref_clk_i;
  sub_indexed_exec dut (.ref_clk_i, .rst_n_i, .instr_valid_i(vld),
    .instr_i(ins), .extended_en_i(ext), .bank_select_register_i(bank_select_register),
    .mem_rdata_i(rd), .return_stack_top_i(return_stack_top), .w_o(w), .status_o(st),
    .fsr0_o(f0), .fsr1_o(f1), .frame_pointer_o(fp), .mem_req_o(mq),
    .pc_load_o(program_counter_low), .pc_target_o(pct), .busy_o(busy));
  sub_exec_mem_model mdl (.ref_clk_i, .mem_req_i(mq), .operand_i(opnd),
    .mem_rdata_o(rd));
  task chk(input string n, input logic [20:0] e, input logic [20:0] s);
    checks_done++;
    if (s !== e)
    begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task put(input logic [15:0] word);
    @(posedge ref_clk_i);
    #1;
    vld = 1;
    ins = word;
  endtask
  task go(input logic [15:0] word);
    put(word);
    @(posedge ref_clk_i);
    #1;
    vld = 0;
  endtask
  task summarize;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (4000) @(posedge ref_clk_i);
    failures++;
    summarize;
  end
  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    #1;
    rst_n_i = 1;
    for (int i = 0; i < 3; i++)
    begin
      go({8'h08, lk[i]});
      chk("w", ew[i], w);
      chk("status", es[i], st);
    end
    $display("test literal done");
    opnd = 8'h35;
    go(16'h5D22);
    chk("w", 8'h35, w);
    bank_select_register = 4'h3;
    opnd = 8'h40;
    // write-back address per bank mode; data stays 40h minus 35h
    for (int i = 0; i < 3; i++)
    begin
      ext = (i == 2);
      go(xi[i]);
      chk("write", {1'b1, xa[i], 8'h0B},
        {mq.we, mq.addr, mq.data});
    end
    $display("test file done");
    go(16'hEAAB);
    chk("fp", 12'hFFF, fp);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("push", 8'hAB, mdl.mem[0]);
    $display("test push done");
    for (int i = 0; i < 3; i++)
      go({8'hE9, i[1:0], 6'h3F});
    chk("fsr0", 12'hFC1, f0);
    chk("fsr1", 12'hFC1, f1);
    chk("fp", 12'hFC0, fp);
    chk("status", 5'h01, st);
    // indexed address only differs from plain access once pointer is nonzero
    go(16'h5E10);
    chk("indexed", {1'b1, 12'hFD0, 8'h0B},
      {mq.we, mq.addr, mq.data});
    $display("test pointer done");
    mdl.mem[12'hFC5] = 8'h33;
    mdl.mem[12'hFE7] = 8'h44;
    mdl.mem[12'hFC8] = 8'h77;
    mdl.mem[12'hFE3] = 8'h55;
    put(16'hEB05);
    go(16'hF006);
    put(16'hEB27);
    go(16'hF008);
    put(16'hEB05);
    go(16'hF023);
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk("move", 8'h33, mdl.mem[12'hFC6]);
    chk("move_src", 8'h00, mdl.mem[12'hFC8]);
    chk("move_dst", 8'h55, mdl.mem[12'hFE3]);
    $display("test move done");
    put(16'hE9E3);
    put(16'h08AA);
    chk("pc_load", 1'b1, program_counter_low);
    chk("busy", 1'b1, busy);
    @(posedge ref_clk_i);
    #1;
    vld = 0;
    chk("pc_load", 1'b0, program_counter_low);
    chk("pc", return_stack_top, pct);
    chk("fp", 12'hF9D, fp);
    chk("w", 8'h35, w);
    $display("test return done");
    summarize;
  end
endmodule
bind sub_indexed_exec sub_indexed_exec_chk chk_i (.ref_clk_i, .rst_n_i,
  .instr_valid_i, .instr_i, .w_o, .status_o, .frame_pointer_o, .mem_req_o,
  .pc_load_o, .busy_o);
`default_nettype wire
